// File: inc/ibs_defs.svh
// Offsets, field positions, reset values and bus codes of the port control
`ifndef IBS_DEFS_SVH
`define IBS_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define IBS_OFF_CTRL 8'h00
`define IBS_OFF_STAT 8'h04
`define IBS_OFF_HSR 8'h08
`define IBS_OFF_HSE 8'h0C
`define IBS_OFF_ESR 8'h10
`define IBS_OFF_ESE 8'h14
`define IBS_OFF_SRE 8'h18
`define IBS_OFF_STB 8'h1C

// ==========================================================================
// Control register fields
`define IBS_CTRL_PROG_REMOTE 0
`define IBS_CTRL_PROG_LOCAL 1
`define IBS_CTRL_CLEAR_STATUS 2
`define IBS_CTRL_TRIGGER 3
`define IBS_CTRL_TALK_ONLY 4
`define IBS_CTRL_TALK_LSB 8
`define IBS_CTRL_LISTEN_LSB 16

// ==========================================================================
// Status byte fields and reset values
`define IBS_STB_HARDWARE_SUMMARY_BIT 0
`define IBS_STB_MAV 4
`define IBS_STB_EVENT_SUMMARY_BIT 5
`define IBS_STB_REQUEST_SERVICE_BIT 6
`define IBS_HSR_USED 16'h07FF
`define IBS_ESR_USED 16'h00FF
`define IBS_ESR_PON 7
`define IBS_ESR_URQ 6
`define IBS_ESR_RESET 16'h0080
`define IBS_DEFAULT_ADDR 5'h03

// ==========================================================================
// Interface command bytes, parity bit stripped
`define IBS_CMD_GTL 7'h01
`define IBS_CMD_SDC 7'h04
`define IBS_CMD_GET 7'h08
`define IBS_CMD_LLO 7'h11
`define IBS_CMD_DCL 7'h14
`define IBS_CMD_UNL 7'h3F
`define IBS_CMD_UNT 7'h5F
`define IBS_LAD_BASE 2'b01
`define IBS_TAD_BASE 2'b10

`endif

// File: inc/ibs_pkg.sv
// Types shared by the instrument bus port control
package ibs_pkg;

  // Byte seen on the instrument bus, one-cycle valid
  typedef struct packed {
    logic valid;
    logic atn;
    logic [7:0] data;
  } ibs_bus_byte_t;

  // Configuration held in non-volatile storage
  typedef struct packed {
    logic talk_only;
    logic [4:0] talk_addr;
    logic [4:0] listen_addr;
  } ibs_nv_cfg_t;

  // Remote and local operating mode
  typedef enum logic [1:0] {
    IBS_LOCAL = 2'b01,
    IBS_REMOTE = 2'b10
  } ibs_mode_t;

endpackage

// File: logic/ibs_top.sv
// Instrument bus port control: modes, addressing, messages, status summary
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ibs_defs.svh"

module ibs_top (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Instrument bus
  input wire ibs_pkg::ibs_bus_byte_t bus_byte_in,
  input wire logic ren_in,
  input wire logic ifc_in,
  output logic srq_out,
  output logic srq_oe_out,
  output logic talk_enable_out,
  output logic listen_active_out,
  // Received data and parser control
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_abort_out,
  output logic dev_clear_out,
  output logic trigger_out,
  // Front panel
  input wire logic local_key_in,
  input wire logic panel_cfg_wr_in,
  input wire ibs_pkg::ibs_nv_cfg_t panel_cfg_in,
  output logic panel_enable_out,
  output logic remote_indicator_lamp_out,
  // Status sources and non-volatile store
  input wire logic [15:0] hw_event_in,
  input wire logic [7:0] esr_event_in,
  input wire logic mav_in,
  input wire ibs_pkg::ibs_nv_cfg_t nv_cfg_in,
  output ibs_pkg::ibs_nv_cfg_t nv_cfg_out
);

  // ========================================================================
  // Helpers
  function automatic logic addr_match(input logic [6:0] cmd,
                                      input logic [1:0] base,
                                      input logic [4:0] addr);
    addr_match = (cmd == {base, addr}) && (addr != 5'h1F);
  endfunction

  function automatic logic off_is(input logic [31:0] a,
                                  input logic [7:0] off);
    off_is = (a[7:0] == off) && (a[31:8] == 24'h000000);
  endfunction

  // ========================================================================
  // State
  ibs_pkg::ibs_mode_t mode_reg;
  ibs_pkg::ibs_mode_t mode_next;
  ibs_pkg::ibs_nv_cfg_t cfg_reg;
  logic lockout_reg;
  logic talker_reg;
  logic listener_reg;
  logic ren_reg;
  logic [15:0] hsr_reg;
  logic [15:0] hse_reg;
  logic [15:0] esr_reg;
  logic [15:0] ese_reg;
  logic [7:0] sre_reg;
  logic request_service_bit_reg;
  logic summary_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rdata_next;

  // ========================================================================
  // Bus message decode
  logic [6:0] cmd;
  logic cmd_valid;
  logic data_valid;
  logic is_mla;
  logic is_mta;
  logic local_clear_lockout_msg;
  logic gtl;
  logic llo;
  logic get_cmd;
  logic dev_clear;

  // Talk-only mode shuts the decoder off entirely
  assign cmd = bus_byte_in.data[6:0];
  assign cmd_valid = bus_byte_in.valid && bus_byte_in.atn &&
                     !cfg_reg.talk_only;
  assign data_valid = bus_byte_in.valid && !bus_byte_in.atn &&
                      !cfg_reg.talk_only;
  assign is_mla = cmd_valid &&
                  addr_match(cmd, `IBS_LAD_BASE, cfg_reg.listen_addr);
  assign is_mta = cmd_valid &&
                  addr_match(cmd, `IBS_TAD_BASE, cfg_reg.talk_addr);
  assign local_clear_lockout_msg = ren_reg && !ren_in &&
                                   !cfg_reg.talk_only;
  assign gtl = cmd_valid && (cmd == `IBS_CMD_GTL);
  assign llo = cmd_valid && (cmd == `IBS_CMD_LLO) && ren_in;
  assign get_cmd = cmd_valid && (cmd == `IBS_CMD_GET);
  assign dev_clear = cmd_valid && ((cmd == `IBS_CMD_DCL) ||
                     ((cmd == `IBS_CMD_SDC) && listener_reg));

  // ========================================================================
  // Register write strobes, data phase
  logic wr_ctrl;
  logic wr_hse;
  logic wr_ese;
  logic wr_sre;
  logic prog_remote;
  logic prog_local;
  logic clear_status;
  logic addr_phase;
  logic rd_hsr;
  logic rd_esr;

  assign wr_ctrl = wr_pend_reg && (wr_addr_reg == `IBS_OFF_CTRL);
  assign wr_hse = wr_pend_reg && (wr_addr_reg == `IBS_OFF_HSE);
  assign wr_ese = wr_pend_reg && (wr_addr_reg == `IBS_OFF_ESE);
  assign wr_sre = wr_pend_reg && (wr_addr_reg == `IBS_OFF_SRE);
  assign prog_remote = wr_ctrl && hwdata_in[`IBS_CTRL_PROG_REMOTE];
  assign prog_local = wr_ctrl && hwdata_in[`IBS_CTRL_PROG_LOCAL];
  assign clear_status = wr_ctrl && hwdata_in[`IBS_CTRL_CLEAR_STATUS];
  assign addr_phase = hsel_in && htrans_in[1] && hready_in;
  assign rd_hsr = addr_phase && !hwrite_in &&
                  off_is(haddr_in, `IBS_OFF_HSR);
  assign rd_esr = addr_phase && !hwrite_in &&
                  off_is(haddr_in, `IBS_OFF_ESR);

  // ========================================================================
  // Remote and local mode
  // Mode is a pure flag; instrument settings live elsewhere and stay put
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      ibs_pkg::IBS_LOCAL: begin
        if ((is_mla && ren_in) || prog_remote) begin
          mode_next = ibs_pkg::IBS_REMOTE;
        end
      end
      ibs_pkg::IBS_REMOTE: begin
        if (local_clear_lockout_msg || gtl) begin
          mode_next = ibs_pkg::IBS_LOCAL;
        end else if (prog_local) begin
          mode_next = ibs_pkg::IBS_LOCAL;
        end else if (local_key_in && !lockout_reg) begin
          mode_next = ibs_pkg::IBS_LOCAL;
        end
      end
      default: begin
        mode_next = ibs_pkg::IBS_LOCAL;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      mode_reg <= ibs_pkg::IBS_LOCAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      lockout_reg <= 1'b0;
    end else if (local_clear_lockout_msg) begin
      lockout_reg <= 1'b0;
    end else if (llo) begin
      lockout_reg <= 1'b1;
    end
  end

  // REN history; starts low so a low REN at reset is no clear-lockout
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ren_reg <= 1'b0;
    end else begin
      ren_reg <= ren_in;
    end
  end

  // ========================================================================
  // Talker and listener addressing
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      talker_reg <= 1'b0;
      listener_reg <= 1'b0;
    end else if (ifc_in || cfg_reg.talk_only) begin
      talker_reg <= 1'b0;
      listener_reg <= 1'b0;
    end else if (cmd_valid) begin
      if (is_mla) begin
        listener_reg <= 1'b1;
        talker_reg <= 1'b0;
      end else if (is_mta) begin
        talker_reg <= 1'b1;
      end else if (cmd == `IBS_CMD_UNT) begin
        talker_reg <= 1'b0;
      end else if (cmd == `IBS_CMD_UNL) begin
        listener_reg <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Configuration, loaded from the store and written back to it
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cfg_reg <= nv_cfg_in;
    end else if (panel_cfg_wr_in) begin
      cfg_reg <= panel_cfg_in;
    end else if (wr_ctrl) begin
      cfg_reg.talk_only <= hwdata_in[`IBS_CTRL_TALK_ONLY];
      cfg_reg.talk_addr <= hwdata_in[`IBS_CTRL_TALK_LSB +: 5];
      cfg_reg.listen_addr <= hwdata_in[`IBS_CTRL_LISTEN_LSB +: 5];
    end
  end

  // ========================================================================
  // Status registers: events set, reads and clear-status clear
  // A new event in the clearing cycle survives the clear
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      hsr_reg <= 16'h0000;
    end else begin
      hsr_reg <= ((rd_hsr || clear_status) ? 16'h0000 : hsr_reg) |
                 (hw_event_in & `IBS_HSR_USED);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      esr_reg <= `IBS_ESR_RESET;
    end else begin
      esr_reg <= ((rd_esr || clear_status) ? 16'h0000 : esr_reg) |
                 ({8'h00, esr_event_in} & `IBS_ESR_USED) |
                 (16'(local_key_in) << `IBS_ESR_URQ);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      hse_reg <= 16'h0000;
      ese_reg <= 16'h0000;
      sre_reg <= 8'h00;
    end else begin
      if (wr_hse) begin
        hse_reg <= hwdata_in[15:0] & `IBS_HSR_USED;
      end
      if (wr_ese) begin
        ese_reg <= hwdata_in[15:0] & `IBS_ESR_USED;
      end
      if (wr_sre) begin
        sre_reg <= hwdata_in[7:0];
      end
    end
  end

  // ========================================================================
  // Status byte and service request
  logic [7:0] stb;
  logic summary;

  always_comb begin
    stb = 8'h00;
    stb[`IBS_STB_HARDWARE_SUMMARY_BIT] = |(hsr_reg & hse_reg);
    stb[`IBS_STB_EVENT_SUMMARY_BIT] = |(esr_reg & ese_reg);
    stb[`IBS_STB_MAV] = mav_in;
    stb[`IBS_STB_REQUEST_SERVICE_BIT] = request_service_bit_reg;
  end

  // Request bit itself is excluded so it cannot feed back into the sum
  assign summary = |(stb & sre_reg &
                     ~(8'h01 << `IBS_STB_REQUEST_SERVICE_BIT));

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      summary_reg <= 1'b0;
      request_service_bit_reg <= 1'b0;
    end else begin
      summary_reg <= summary;
      if (summary && !summary_reg) begin
        request_service_bit_reg <= 1'b1;
      end else if (!summary || clear_status) begin
        request_service_bit_reg <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Outgoing bus and panel signals
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      srq_out <= 1'b0;
      srq_oe_out <= 1'b0;
      talk_enable_out <= 1'b0;
      listen_active_out <= 1'b0;
      panel_enable_out <= 1'b1;
      remote_indicator_lamp_out <= 1'b0;
      nv_cfg_out <= '0;
    end else begin
      // Open-drain pull low while requesting; mode is not consulted
      srq_out <= 1'b0;
      srq_oe_out <= request_service_bit_reg;
      talk_enable_out <= talker_reg || cfg_reg.talk_only;
      listen_active_out <= listener_reg;
      panel_enable_out <= (mode_reg == ibs_pkg::IBS_LOCAL);
      remote_indicator_lamp_out <=
        (mode_reg == ibs_pkg::IBS_REMOTE);
      nv_cfg_out <= cfg_reg;
    end
  end

  // ========================================================================
  // Received data and parser control pulses
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rx_data_out <= 8'h00;
      rx_valid_out <= 1'b0;
      rx_abort_out <= 1'b0;
      dev_clear_out <= 1'b0;
      trigger_out <= 1'b0;
    end else begin
      rx_valid_out <= data_valid && listener_reg && !ifc_in &&
                      (mode_reg == ibs_pkg::IBS_REMOTE);
      if (data_valid) begin
        rx_data_out <= bus_byte_in.data;
      end
      rx_abort_out <= ifc_in && !cfg_reg.talk_only;
      dev_clear_out <= dev_clear;
      trigger_out <= get_cmd ||
                     (wr_ctrl && hwdata_in[`IBS_CTRL_TRIGGER]);
    end
  end

  // ========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  // Read data is sampled in the address phase, so a read right behind
  // a write to the same register returns the old value
  always_comb begin
    rdata_next = 32'h00000000;
    if (off_is(haddr_in, `IBS_OFF_CTRL)) begin
      rdata_next[`IBS_CTRL_TALK_ONLY] = cfg_reg.talk_only;
      rdata_next[`IBS_CTRL_TALK_LSB +: 5] = cfg_reg.talk_addr;
      rdata_next[`IBS_CTRL_LISTEN_LSB +: 5] = cfg_reg.listen_addr;
    end else if (off_is(haddr_in, `IBS_OFF_STAT)) begin
      rdata_next[0] = (mode_reg == ibs_pkg::IBS_REMOTE);
      rdata_next[1] = lockout_reg;
      rdata_next[2] = talker_reg;
      rdata_next[3] = listener_reg;
    end else if (off_is(haddr_in, `IBS_OFF_HSR)) begin
      rdata_next[15:0] = hsr_reg;
    end else if (off_is(haddr_in, `IBS_OFF_HSE)) begin
      rdata_next[15:0] = hse_reg;
    end else if (off_is(haddr_in, `IBS_OFF_ESR)) begin
      rdata_next[15:0] = esr_reg;
    end else if (off_is(haddr_in, `IBS_OFF_ESE)) begin
      rdata_next[15:0] = ese_reg;
    end else if (off_is(haddr_in, `IBS_OFF_SRE)) begin
      rdata_next[7:0] = sre_reg;
    end else if (off_is(haddr_in, `IBS_OFF_STB)) begin
      rdata_next[7:0] = stb;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite_in &&
                     (haddr_in[31:8] == 24'h000000);
      wr_addr_reg <= haddr_in[7:0];
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      if (addr_phase && !hwrite_in) begin
        hrdata_out <= rdata_next;
      end
    end
  end

  // Unused: only whole-word accesses are supported
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize_in};

endmodule // ibs_top

`default_nettype wire

// File: tb/ibs_ctrl_model.sv
// Bus controller model driving the instrument bus lines
`timescale 1ns/1ps
`default_nettype none

module ibs_ctrl_model (
  // Clock
  input wire logic ref_clk_in,
  // Instrument bus lines
  output ibs_pkg::ibs_bus_byte_t bus_byte_out,
  output logic ren_out,
  output logic ifc_out
);
  initial begin
    bus_byte_out = '0;
    ren_out = 1'b0;
    ifc_out = 1'b0;
  end

  // One byte per valid; ATN chosen per byte
  task automatic send(input logic atn, input logic [7:0] d);
    @(posedge ref_clk_in);
    bus_byte_out <= {1'b1, atn, d};
    @(posedge ref_clk_in);
    // Released lines must not echo the last byte
    bus_byte_out <= {1'b0, ~atn, ~d};
  endtask

  task automatic set_ren(input logic v);
    @(posedge ref_clk_in);
    ren_out <= v;
  endtask

  task automatic pulse_ifc();
    @(posedge ref_clk_in);
    ifc_out <= 1'b1;
    @(posedge ref_clk_in);
    ifc_out <= 1'b0;
  endtask
endmodule // ibs_ctrl_model

`default_nettype wire

// File: tb/ibs_top_asserts.sv
// Concurrent checks on the port control pins
`timescale 1ns/1ps
`default_nettype none
`include "ibs_defs.svh"

module ibs_top_asserts (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Bus side
  input wire ibs_pkg::ibs_bus_byte_t bus_byte_in,
  input wire logic ren_in,
  input wire logic ifc_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // Results
  input wire logic talk_enable_out,
  input wire logic listen_active_out,
  input wire logic [7:0] rx_data_out,
  input wire logic rx_valid_out,
  input wire logic rx_abort_out,
  input wire logic dev_clear_out,
  input wire logic trigger_out,
  input wire logic panel_enable_out,
  input wire logic remote_indicator_lamp_out,
  input wire ibs_pkg::ibs_nv_cfg_t nv_cfg_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  // =======================================
  // Helpers
  logic live;
  assign live = !nv_cfg_out.talk_only;

  sequence s_cmd(logic [6:0] c);
    bus_byte_in.valid && bus_byte_in.atn && bus_byte_in.data[6:0] == c && live;
  endsequence
  sequence s_data;
    bus_byte_in.valid && !bus_byte_in.atn;
  endsequence

  // =======================================
  // Checks
  a_lamp_panel: assert property (
    remote_indicator_lamp_out != panel_enable_out)
    else $error("lamp and panel enable agree");
  a_gtl_local: assert property (
    s_cmd(`IBS_CMD_GTL) |=> ##[0:2] !remote_indicator_lamp_out)
    else $error("go to local ignored");
  a_ren_fall: assert property (
    $fell(ren_in) && live |=> ##[0:2] !remote_indicator_lamp_out)
    else $error("remote kept after enable fell");
  a_get_trig: assert property (
    s_cmd(`IBS_CMD_GET) |=> trigger_out)
    else $error("group trigger missed");
  a_dcl_clear: assert property (
    s_cmd(`IBS_CMD_DCL) |=> dev_clear_out)
    else $error("device clear missed");
  a_unt_talk: assert property (
    s_cmd(`IBS_CMD_UNT) |=> ##[0:2] !talk_enable_out)
    else $error("talker kept after untalk");
  a_ifc_drop: assert property (
    ifc_in && live |=> rx_abort_out ##[0:1]
      (!listen_active_out && !talk_enable_out))
    else $error("interface clear not honoured");
  a_data_take: assert property (
    rx_valid_out |-> $past(bus_byte_in.valid && !bus_byte_in.atn)
      && rx_data_out == $past(bus_byte_in.data))
    else $error("data taken without data byte");
  a_talk_only: assert property (
    nv_cfg_out.talk_only [*2] |-> talk_enable_out)
    else $error("talk only without talk enable");
  a_ahb_okay: assert property (
    hreadyout_out && !hresp_out)
    else $error("bus slave stalled or erred");
  c_data: cover property (s_data);
endmodule // ibs_top_asserts

bind ibs_top ibs_top_asserts u_chk (
  .ref_clk_in, .reset_in, .bus_byte_in, .ren_in, .ifc_in,
  .hreadyout_out, .hresp_out, .talk_enable_out, .listen_active_out,
  .rx_data_out, .rx_valid_out, .rx_abort_out, .dev_clear_out,
  .trigger_out, .panel_enable_out, .remote_indicator_lamp_out, .nv_cfg_out
);

`default_nettype wire

// File: tb/instrument_bus_remote_local_status_bench.sv
// Self-checking bench for the instrument bus port control
`timescale 1ns/1ps
`default_nettype none
`include "ibs_defs.svh"

module instrument_bus_remote_local_status_bench;
  localparam ibs_pkg::ibs_nv_cfg_t def_cfg = {1'b0, 5'h03, 5'h03};
  localparam logic [7:0] lad = {1'b0, `IBS_LAD_BASE, `IBS_DEFAULT_ADDR};
  localparam logic [7:0] tad = {1'b0, `IBS_TAD_BASE, `IBS_DEFAULT_ADDR};
  localparam logic [31:0] ctrl_base = 32'h0003_0300;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic hsel_in = 1'b0;
  logic hwrite_in = 1'b0;
  logic local_key_in = 1'b0;
  logic panel_cfg_wr_in = 1'b0;
  logic [31:0] haddr_in = '0, hwdata_in = '0, hrdata_out, rd;
  logic [1:0] htrans_in = '0;
  logic [15:0] hw_event_in = '0;
  logic [7:0] esr_event_in = '0;
  logic mav_in = 1'b0;
  logic hreadyout_out, hresp_out, srq_out, srq_oe_out, ren_in, ifc_in;
  logic talk_enable_out, listen_active_out, rx_valid_out, rx_abort_out;
  logic dev_clear_out, trigger_out, panel_enable_out;
  logic remote_indicator_lamp_out;
  logic [7:0] rx_data_out;
  ibs_pkg::ibs_bus_byte_t bus_byte_in;
  ibs_pkg::ibs_nv_cfg_t panel_cfg_in = def_cfg, nv_cfg_out;
  int mismatches = 0, checked = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  ibs_ctrl_model u_ctl (.ref_clk_in, .bus_byte_out(bus_byte_in),
    .ren_out(ren_in), .ifc_out(ifc_in));
  ibs_top u_dut (.ref_clk_in, .reset_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in(3'b010), .hwdata_in, .hready_in(hreadyout_out),
    .hrdata_out, .hreadyout_out, .hresp_out, .bus_byte_in, .ren_in, .ifc_in,
    .srq_out, .srq_oe_out, .talk_enable_out, .listen_active_out,
    .rx_data_out, .rx_valid_out, .rx_abort_out, .dev_clear_out, .trigger_out,
    .local_key_in, .panel_cfg_wr_in, .panel_cfg_in, .panel_enable_out,
    .remote_indicator_lamp_out, .hw_event_in, .esr_event_in,
    .mav_in, .nv_cfg_in(def_cfg), .nv_cfg_out);

  // =======================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'b10;
    haddr_in <= {24'h0, a};
    hwrite_in <= w;
    @(posedge ref_clk_in);
    while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= d;
    @(posedge ref_clk_in);
    while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
    rd = hrdata_out;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic key();
    @(posedge ref_clk_in);
    local_key_in <= 1'b1;
    @(posedge ref_clk_in);
    local_key_in <= 1'b0;
  endtask

  task automatic panel(input ibs_pkg::ibs_nv_cfg_t c);
    @(posedge ref_clk_in);
    panel_cfg_in <= c;
    panel_cfg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    panel_cfg_wr_in <= 1'b0;
  endtask

  // =======================================
  // Scenarios
  task automatic t_reset();
    chk(remote_indicator_lamp_out, 0, "lamp after reset");
    chk(panel_enable_out, 1, "panel after reset");
    chk(listen_active_out | talk_enable_out, 0, "addressed");
    chk(srq_oe_out, 0, "service request after reset");
    chk(nv_cfg_out, def_cfg, "stored config");
    ahb(0, `IBS_OFF_STB, 0);
    chk(rd, 0, "status byte after reset");
    ahb(0, 8'h40, 0);
    chk(rd, 0, "unmapped read");
    $display("test reset done");
  endtask

  task automatic t_remote();
    ahb(1, `IBS_OFF_HSE, 32'h4);
    u_ctl.set_ren(1'b1);
    u_ctl.send(1'b1, lad);
    wt(3);
    chk(remote_indicator_lamp_out, 1, "listen address remote");
    chk(panel_enable_out, 0, "panel locked");
    u_ctl.send(1'b0, 8'h5A);
    #1;
    chk(rx_valid_out, 1, "data accepted");
    chk(rx_data_out, 8'h5A, "data byte");
    key();
    wt(3);
    chk(remote_indicator_lamp_out, 0, "key returns local");
    u_ctl.send(1'b0, 8'hA5);
    #1;
    chk(rx_valid_out, 0, "data refused in local");
    u_ctl.send(1'b1, lad);
    u_ctl.send(1'b1, {1'b0, `IBS_CMD_LLO});
    key();
    wt(3);
    chk(remote_indicator_lamp_out, 1, "key locked out");
    ahb(0, `IBS_OFF_STAT, 0);
    chk(rd[1], 1, "lockout set");
    u_ctl.send(1'b1, {1'b0, `IBS_CMD_GTL});
    wt(3);
    chk(remote_indicator_lamp_out, 0, "go to local");
    u_ctl.send(1'b1, lad);
    key();
    wt(3);
    chk(remote_indicator_lamp_out, 1, "lockout held");
    u_ctl.set_ren(1'b0);
    wt(3);
    chk(remote_indicator_lamp_out, 0, "enable false local");
    ahb(0, `IBS_OFF_STAT, 0);
    chk(rd[1:0], 0, "lockout cleared");
    ahb(0, `IBS_OFF_HSE, 0);
    chk(rd, 32'h4, "setting kept");
    $display("test remote done");
  endtask

  task automatic t_addr();
    u_ctl.send(1'b1, tad);
    wt(3);
    chk(talk_enable_out, 1, "talker in local");
    u_ctl.send(1'b1, {1'b0, `IBS_CMD_UNT});
    wt(3);
    chk(talk_enable_out, 0, "untalk");
    u_ctl.send(1'b1, lad);
    wt(3);
    chk(listen_active_out, 1, "listener");
    u_ctl.pulse_ifc();
    #1;
    chk(rx_abort_out, 1, "data aborted");
    wt(3);
    chk(listen_active_out, 0, "clear drops listener");
    u_ctl.send(1'b1, {1'b0, `IBS_CMD_GET});
    #1;
    chk(trigger_out, 1, "group trigger");
    u_ctl.send(1'b1, {1'b0, `IBS_CMD_DCL});
    #1;
    chk(dev_clear_out, 1, "device clear");
    u_ctl.send(1'b1, lad);
    u_ctl.send(1'b1, {1'b0, `IBS_CMD_SDC});
    #1;
    chk(dev_clear_out, 1, "selected clear");
    ahb(1, `IBS_OFF_CTRL, ctrl_base | 32'h8);
    #1;
    chk(trigger_out, 1, "trigger command");
    ahb(1, `IBS_OFF_CTRL, ctrl_base | 32'h1);
    wt(3);
    chk(remote_indicator_lamp_out, 1, "remote command");
    ahb(1, `IBS_OFF_CTRL, ctrl_base | 32'h2);
    wt(3);
    chk(remote_indicator_lamp_out, 0, "local command");
    $display("test addressing done");
  endtask

  task automatic t_srq();
    ahb(1, `IBS_OFF_ESE, 32'h80);
    ahb(1, `IBS_OFF_SRE, 32'h20);
    wt(3);
    chk(srq_oe_out, 1, "event summary request");
    chk(srq_out, 0, "request pulls line low");
    ahb(0, `IBS_OFF_STB, 0);
    chk(rd, 32'h60, "event summary bit");
    ahb(1, `IBS_OFF_SRE, 32'h01);
    wt(3);
    chk(srq_oe_out, 0, "request dropped");
    @(posedge ref_clk_in);
    hw_event_in <= 16'h0004;
    @(posedge ref_clk_in);
    hw_event_in <= 16'h0000;
    wt(3);
    chk(srq_oe_out, 1, "hardware summary request");
    ahb(0, `IBS_OFF_STB, 0);
    chk(rd, 32'h61, "hardware summary bit");
    // Level held: clearing must not re-raise the request
    hw_event_in <= 16'h0004;
    ahb(1, `IBS_OFF_CTRL, ctrl_base | 32'h4);
    wt(3);
    chk(srq_oe_out, 0, "level does not request");
    @(posedge ref_clk_in);
    hw_event_in <= 16'h0000;
    mav_in <= 1'b1;
    esr_event_in <= 8'h10;
    @(posedge ref_clk_in);
    esr_event_in <= 8'h00;
    ahb(0, `IBS_OFF_STB, 0);
    chk(rd, 32'h11, "message available bit");
    ahb(0, `IBS_OFF_ESR, 0);
    chk(rd, 32'h10, "event status set");
    ahb(0, `IBS_OFF_ESR, 0);
    chk(rd, 0, "event status cleared by read");
    ahb(0, `IBS_OFF_HSR, 0);
    chk(rd, 32'h4, "hardware status set");
    ahb(0, `IBS_OFF_HSR, 0);
    chk(rd, 0, "hardware status cleared by read");
    mav_in <= 1'b0;
    $display("test service request done");
  endtask

  task automatic t_talk_only();
    panel({1'b1, 5'h03, 5'h03});
    wt(3);
    chk(talk_enable_out, 1, "talk only talks");
    chk(nv_cfg_out.talk_only, 1, "mode stored");
    u_ctl.set_ren(1'b1);
    u_ctl.send(1'b1, lad);
    wt(3);
    chk(remote_indicator_lamp_out, 0, "bus ignored");
    panel(def_cfg);
    u_ctl.set_ren(1'b0);
    $display("test talk only done");
  endtask

  // =======================================
  // Verdict
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    wt(2);
    t_reset();
    t_remote();
    t_addr();
    t_srq();
    t_talk_only();
    end_sim();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #100us;
    mismatches++;
    end_sim();
  end
endmodule // instrument_bus_remote_local_status_bench

`default_nettype wire
